// >>> bench/flag_ops_core_asserts.sv
module flag_ops_core_asserts
    import alu_pkg::*;
(
    // Clock, reset and request
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic op_valid,
    input wire op_t op,
    input wire logic [7:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic acc_load,
    input wire logic status_load,
    input wire logic time_out_set,
    input wire logic power_down_set,
    // Results
    input wire mem_wr_t mem_wr,
    input wire logic [7:0] working_register,
    input wire status_t status,
    input wire logic watchdog_clear
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_op(op_t o);
        op_valid && op == o;
    endsequence
    sequence s_adjust;
        s_op(decimal_adjust_op);
    endsequence
    sequence s_high_only;
        s_adjust ##0 (working_register[7:4] > 4'h9 || status.carry) ##0
            !(working_register[3:0] > 4'h9 || status.aux_carry_flag);
    endsequence
    AST_WD_CLEAR: assert property (
        s_op(watchdog_clear_op) ##0 !time_out_set && !power_down_set
        |=> watchdog_clear && !status.time_out_flag &&
        !status.power_down_flag) else $error("watchdog clear wrong");
    AST_WD_ONLY: assert property (
        watchdog_clear |-> $past(op_valid && op == watchdog_clear_op))
        else $error("stray watchdog clear");
    AST_INV_MEM: assert property (
        s_op(complement_memory_op) |=> mem_wr.en &&
        mem_wr.addr == $past(mem_addr) && mem_wr.data == ~$past(mem_rdata))
        else $error("complement write wrong");
    AST_INV_LOAD: assert property (
        s_op(complement_to_acc_op) |=> !mem_wr.en &&
        working_register == ~$past(mem_rdata))
        else $error("complement load wrong");
    AST_ZERO: assert property (
        op_valid && (op == complement_memory_op ||
        op == complement_to_acc_op) |=>
        status.zero == ($past(mem_rdata) == 8'hff))
        else $error("zero flag wrong");
    AST_LOW: assert property (
        s_adjust ##0 (working_register[3:0] > 4'h9 || status.aux_carry_flag)
        |=> mem_wr.data[3:0] == $past(working_register[3:0]) + 4'h6)
        else $error("low fix wrong");
    AST_HIGH: assert property (
        s_high_only |=> mem_wr.data == $past(working_register) + 8'h60)
        else $error("high fix wrong");
    AST_ADJ_KEEP: assert property (
        s_adjust ##0 !acc_load |=> mem_wr.en && $stable(working_register))
        else $error("adjust changed accumulator");
    AST_FLAGS: assert property (
        s_adjust ##0 !status_load && !time_out_set && !power_down_set
        |=> $stable({status.time_out_flag, status.power_down_flag,
        status.zero, status.aux_carry_flag}))
        else $error("adjust changed flags");
    AST_CARRY: assert property (
        s_adjust ##0 status.carry |=> status.carry)
        else $error("adjust lost carry");
endmodule

bind flag_ops_core flag_ops_core_asserts chk (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .op_valid(op_valid),
    .op(op),
    .mem_addr(mem_addr),
    .mem_rdata(mem_rdata),
    .acc_load(acc_load),
    .status_load(status_load),
    .time_out_set(time_out_set),
    .power_down_set(power_down_set),
    .mem_wr(mem_wr),
    .working_register(working_register),
    .status(status),
    .watchdog_clear(watchdog_clear)
);

// >>> bench/tb_flag_ops_core.sv
module tb_flag_ops_core;
    import alu_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = '0, rst_b = '0, op_valid = '0, acc_load = '0;
    logic status_load = '0, time_out_set = '0, power_down_set = '0;
    logic op_done, watchdog_clear;
    logic [7:0] mem_addr = '0, mem_rdata = '0, acc_load_val = '0;
    logic [7:0] working_register, acc_m, adj;
    logic [8:0] s;
    logic [31:0] r;
    logic [30:0] exp_q[$];
    status_t status_load_val = '0, status, st_m;
    mem_wr_t mem_wr, mw;
    op_t op = watchdog_clear_op, o;
    int err_total = 0, n_compared = 0, seed = 32'h0000_91de;
    flag_ops_core dut (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .op_valid(op_valid),
        .op(op),
        .mem_addr(mem_addr),
        .mem_rdata(mem_rdata),
        .acc_load(acc_load),
        .acc_load_val(acc_load_val),
        .status_load(status_load),
        .status_load_val(status_load_val),
        .time_out_set(time_out_set),
        .power_down_set(power_down_set),
        .op_done(op_done),
        .mem_wr(mem_wr),
        .working_register(working_register),
        .status(status),
        .watchdog_clear(watchdog_clear)
    );
    initial forever #2 core_clk = ~core_clk;
    task automatic check(string name, logic [30:0] seen, logic [30:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task final_report;
        if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Results are matched in issue order, one per op_done pulse.
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        if (op_done === 1'b1 && exp_q.size() == 0) begin
            check("op_done", 31'h1, 31'h0);
        end else if (op_done === 1'b1) begin
            check("outputs", {mem_wr, working_register, status, watchdog_clear},
                exp_q.pop_front());
        end
    end
    initial begin
        repeat (2000) @(posedge core_clk);
        err_total++;
        final_report;
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        check("reset", {mem_wr, working_register, status, watchdog_clear},
            '0);
        for (int i = 0; i < 200; i++) begin
            r = $random(seed);
            acc_m = r[12:5];
            st_m = r[4:0];
            {op_valid, time_out_set, power_down_set} <= '0;
            {acc_load, status_load} <= 2'h3;
            acc_load_val <= acc_m;
            status_load_val <= st_m;
            @(posedge core_clk);
            o = op_t'(i[1:0]);
            mw = '0;
            st_m.time_out_flag = r[29] | (o != 0 && st_m.time_out_flag);
            st_m.power_down_flag = r[30] | (o != 0 && st_m.power_down_flag);
            case (o)
                complement_memory_op: mw = {1'b1, r[28:21], ~r[20:13]};
                complement_to_acc_op: acc_m = ~r[20:13];
                decimal_adjust_op: begin
                    adj[7:4] = acc_m[7:4] > 9 || st_m.carry ? 4'h6 : 4'h0;
                    adj[3:0] = acc_m[3:0] > 9 || st_m.aux_carry_flag ? 4'h6 : 4'h0;
                    s = {1'b0, acc_m} + adj;
                    st_m.carry = st_m.carry | s[8] | adj[6];
                    mw = {1'b1, r[28:21], s[7:0]};
                end
                default: ;
            endcase
            if (o == 1 || o == 2) st_m.zero = r[20:13] == 8'hff;
            exp_q.push_back({mw, acc_m, st_m, o == watchdog_clear_op});
            {acc_load, status_load, op_valid} <= 3'h1;
            {power_down_set, time_out_set} <= r[30:29];
            op <= o;
            mem_addr <= r[28:21];
            mem_rdata <= r[20:13];
            @(posedge core_clk);
        end
        op_valid <= '0;
        repeat (3) @(posedge core_clk);
        check("pending", 31'(exp_q.size()), 31'h0);
        final_report;
    end
endmodule

// >>> src/alu_pkg.sv
package alu_pkg;

    // ------------------------------------------------------------
    // Widths and constants
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [3:0] NIBBLE_MAX = 4'h9;
    localparam logic [3:0] NIBBLE_FIX = 4'h6;
    localparam logic [7:0] ADJ_NONE = 8'h00;
    localparam logic [7:0] ADJ_LOW = 8'h06;
    localparam logic [7:0] ADJ_HIGH = 8'h60;
    localparam logic [7:0] ADJ_BOTH = 8'h66;
    localparam logic [7:0] ACC_RESET = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        watchdog_clear_op,
        complement_memory_op,
        complement_to_acc_op,
        decimal_adjust_op
    } op_t;

    typedef struct packed {
        logic time_out_flag;
        logic power_down_flag;
        logic zero;
        logic carry;
        logic aux_carry_flag;
    } status_t;

    localparam status_t STATUS_RESET = '0;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } mem_wr_t;

    localparam mem_wr_t MEM_WR_IDLE = '0;

endpackage

// >>> src/bcd_adjust.sv
module bcd_adjust
    import alu_pkg::*;
(
    // Operand and flags
    input wire logic [7:0] acc,
    input wire logic carry_in,
    input wire logic aux_in,
    // Result
    output logic [7:0] result,
    output logic carry_out
);

    logic fix_low;
    logic fix_high;
    logic [7:0] adj;
    logic [8:0] sum;

    always_comb begin
        fix_low = (acc[3:0] > NIBBLE_MAX) || aux_in; // [RULE4]
        fix_high = (acc[7:4] > NIBBLE_MAX) || carry_in; // [RULE5]
        unique case ({fix_high, fix_low})
            2'b00: adj = ADJ_NONE;
            2'b01: adj = ADJ_LOW;
            2'b10: adj = ADJ_HIGH;
            2'b11: adj = ADJ_BOTH;
        endcase
        // One addition of the chosen constant does both corrections.
        sum = {1'b0, acc} + {1'b0, adj}; // [RULE6]
        result = sum[7:0];
        // A carry that was already set stays set so chained digits work.
        carry_out = carry_in || sum[8] || fix_high; // [RULE7]
    end

endmodule

// >>> src/flag_ops_core.sv
// How it works
// [RULE1] Watchdog clear resets counter, time-out flag and power-down flag.
// [RULE2] Complement-memory writes inverted byte back; only zero changes.
// [RULE3] Complement-to-accumulator loads the inverted byte; zero flag only.
// [RULE4] Decimal adjust adds 6 to low nibble if above 9 or aux carry set.
// [RULE5] Decimal adjust adds 6 to high nibble if above 9 or carry set.
// [RULE6] The correction is one addition of 00H, 06H, 60H or 66H.
// [RULE7] Decimal adjust alters only carry; carry set when BCD sum exceeds 99. Here carry stays clear when the low fix takes a high nibble of 9 to A.
// [RULE8] Adjusted result goes to the addressed byte, not the accumulator.
// [RULE9] Zero flag is set when the 8-bit result is zero, else cleared.
module flag_ops_core
    import alu_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Instruction request
    input wire logic op_valid,
    input wire op_t op,
    input wire logic [7:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    // Updates from the rest of the core
    input wire logic acc_load,
    input wire logic [7:0] acc_load_val,
    input wire logic status_load,
    input wire status_t status_load_val,
    input wire logic time_out_set,
    input wire logic power_down_set,
    // Results
    output logic op_done,
    output mem_wr_t mem_wr,
    output logic [7:0] working_register,
    output status_t status,
    output logic watchdog_clear
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Zero test shared by both complement instructions.
    function automatic logic zero_of(input logic [7:0] v);
        zero_of = (v == 8'h00); // [RULE9]
    endfunction

    // True when the given instruction is taken at this edge.
    function automatic logic op_is(
        input logic valid,
        input op_t code,
        input op_t want
    );
        op_is = valid && (code == want);
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Each instruction is decoded once here; the state groups below only
    // look at these strobes, so a new instruction touches one place.
    logic take_wd_clear;
    logic take_inv_mem;
    logic take_inv_acc;
    logic take_bcd_fix;
    logic [7:0] inv;

    always_comb begin
        take_wd_clear = op_is(op_valid, op, watchdog_clear_op);
        take_inv_mem = op_is(op_valid, op, complement_memory_op);
        take_inv_acc = op_is(op_valid, op, complement_to_acc_op);
        take_bcd_fix = op_is(op_valid, op, decimal_adjust_op);
        inv = ~mem_rdata;
    end

    // ------------------------------------------------------------
    // Decimal adjust
    // ------------------------------------------------------------
    logic [7:0] acc_r;
    status_t status_r;
    logic [7:0] bcd_result;
    logic bcd_carry;

    // The adjuster reads the registered accumulator and flags, so the
    // result of an instruction in the previous cycle is already seen.
    // Limitation: the high correction judges the nibble before the low
    // correction, so a carry out of the low nibble is not corrected again.
    bcd_adjust u_bcd_adjust (
        .acc(acc_r),
        .carry_in(status_r.carry),
        .aux_in(status_r.aux_carry_flag),
        .result(bcd_result),
        .carry_out(bcd_carry)
    );

    // ------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------
    logic [7:0] acc_nxt;

    // A complement load wins over a load from the rest of the core.
    // Decimal adjust never writes here; its result goes to memory.
    always_comb begin
        acc_nxt = acc_r;
        if (acc_load) begin
            acc_nxt = acc_load_val;
        end
        if (take_inv_acc) begin
            acc_nxt = inv; // [RULE3]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            acc_r <= ACC_RESET;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    status_t status_nxt;

    always_comb begin
        status_nxt = status_r;
        // A load from the rest of the core comes first so an instruction wins.
        if (status_load) begin
            status_nxt = status_load_val;
        end
        if (take_wd_clear) begin
            status_nxt.time_out_flag = 1'b0; // [RULE1]
            status_nxt.power_down_flag = 1'b0; // [RULE1]
        end
        if (take_inv_mem || take_inv_acc) begin
            status_nxt.zero = zero_of(inv); // [RULE2]
        end
        // Decimal adjust leaves zero alone and only moves carry.
        if (take_bcd_fix) begin
            status_nxt.carry = bcd_carry; // [RULE7]
        end
        // A time-out or power-down event in the same cycle as a clear
        // must not be lost, so the hardware set wins.
        if (time_out_set) begin
            status_nxt.time_out_flag = 1'b1;
        end
        if (power_down_set) begin
            status_nxt.power_down_flag = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            status_r <= STATUS_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    // ------------------------------------------------------------
    // Memory write
    // ------------------------------------------------------------
    mem_wr_t mem_wr_r;
    mem_wr_t mem_wr_nxt;

    // The write is a one-cycle strobe; memory must take it at the next
    // edge, since nothing here holds it for a slow store.
    always_comb begin
        mem_wr_nxt = MEM_WR_IDLE;
        if (take_inv_mem) begin
            mem_wr_nxt.en = 1'b1; // [RULE2]
            mem_wr_nxt.addr = mem_addr;
            mem_wr_nxt.data = inv; // [RULE2]
        end
        if (take_bcd_fix) begin
            mem_wr_nxt.en = 1'b1; // [RULE8]
            mem_wr_nxt.addr = mem_addr;
            mem_wr_nxt.data = bcd_result; // [RULE8]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            mem_wr_r <= MEM_WR_IDLE;
        end else begin
            mem_wr_r <= mem_wr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Completion pulses
    // ------------------------------------------------------------
    logic done_r;
    logic done_nxt;
    logic wd_clear_r;
    logic wd_clear_nxt;

    // The watchdog counter lives outside this block and only sees the
    // pulse; it must clear on the cycle the pulse stands.
    always_comb begin
        done_nxt = op_valid;
        wd_clear_nxt = take_wd_clear; // [RULE1]
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            done_r <= 1'b0;
            wd_clear_r <= 1'b0;
        end else begin
            done_r <= done_nxt;
            wd_clear_r <= wd_clear_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output comes straight from a flip-flop, so the rest of the
    // core sees no path from a request to a result in the same cycle.
    assign working_register = acc_r;
    assign status = status_r;
    assign mem_wr = mem_wr_r;
    assign op_done = done_r;
    assign watchdog_clear = wd_clear_r;

endmodule
